//--- ufab_pkg.sv
// Shared constants for the serial port ends: register map, fields, codes, timing
package ufab_pkg;
  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MODE = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_OWN_ADDR = 8'h0c;
  localparam logic [7:0] OFF_ADDR_MASK = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_IRQ_FLAGS = 8'h18;
  localparam logic [7:0] OFF_PHASE_INC = 8'h1c;
  localparam logic [7:0] OFF_RATE_ERR = 8'h20;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTRL_RX_DONE = 0;
  localparam int CTRL_TX_DONE = 1;
  localparam int CTRL_RX_BIT9 = 2;
  localparam int CTRL_TX_BIT9 = 3;
  localparam int CTRL_RX_EN = 4;
  localparam int CTRL_MULTIDROP = 5;
  localparam int CTRL_MODE_BIT1 = 6;
  localparam int CTRL_MODE_BIT0 = 7;
  localparam int MODE_DOUBLER = 0;
  localparam int MODE_FAULT_VIEW = 1;
  localparam int MODE_GEN_EN = 2;
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [2:0] RST_MODE = 3'h0;
  localparam logic [7:0] RST_ADDR = 8'h00;
  localparam logic [1:0] RST_IRQ_MASK = 2'h0;
  localparam logic [15:0] RST_PHASE_INC = 16'h0000;
  localparam logic [7:0] RST_RATE_ERR = 8'h00;
  // ************************************************************
  // Codes and timing
  // ************************************************************
  localparam logic [7:0] CMD_ARM_BYTE = 8'hfe;
  localparam logic [7:0] CMD_SOFT_RESET = 8'hfe;
  localparam logic [7:0] CMD_PROG_LOAD = 8'hfd;
  localparam logic [3:0] SAMPLE_LAST = 4'hf;
  localparam logic [3:0] VOTE_FIRST = 4'h7;
  localparam logic [3:0] VOTE_LAST = 4'h9;
  localparam logic [3:0] BREAK_BITS = 4'hc;
  typedef enum logic [1:0] {KIND_BYTE, KIND_BREAK, KIND_COMMAND} ufab_kind_type;
endpackage

//--- ufab_link_if.sv
// Serial link between the host end and the device end
`timescale 1ns/1ns
`default_nettype none
interface ufab_link_if;
  logic rx_line;
  logic tx_line;
  modport dev (input rx_line, output tx_line);
  modport host (output rx_line, input tx_line);
endinterface
`default_nettype wire

//--- ufab_host.sv
// Host end: sends bytes, breaks and armed command sequences on the link
`timescale 1ns/1ns
`default_nettype none
module ufab_host (
  input wire logic hclk,
  input wire logic hresetn,
  ufab_link_if.host link,
  input wire logic [15:0] bit_cycles,
  input wire logic nine_bit,
  input wire logic send_valid,
  input wire ufab_pkg::ufab_kind_type send_kind,
  input wire logic [7:0] send_data,
  input wire logic send_ninth,
  output logic send_ready
);
  import ufab_pkg::*;
  logic [15:0] cnt_q;
  logic [12:0] sh_q;
  logic [3:0] left_q;
  logic [1:0] step_q;
  logic [7:0] cmd_q;
  logic busy_q;
  logic bit_en;
  logic [12:0] frame_v;

  // ************************************************************
  // Bit timing
  // ************************************************************
  assign bit_en = busy_q && (cnt_q == bit_cycles - 16'h0001);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 16'h0000;
    end else if (!busy_q || bit_en) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  function automatic logic [12:0] frame_of(input logic [7:0] d, input logic b9, input logic nb);
    frame_of = nb ? {3'b111, b9, d, 1'b0} : {4'b1111, d, 1'b0};
  endfunction

  // ************************************************************
  // Element sequencer
  // ************************************************************
  always_comb begin
    frame_v = frame_of(send_data, send_ninth, nine_bit);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh_q <= 13'h1fff;
      left_q <= 4'h0;
      step_q <= 2'h0;
      cmd_q <= 8'h00;
      busy_q <= 1'b0;
    end else if (!busy_q) begin
      if (send_valid && send_ready) begin
        busy_q <= 1'b1;
        if (send_kind == KIND_BYTE) begin
          sh_q <= frame_v;
          left_q <= nine_bit ? 4'hb : 4'ha;
        end else begin
          // Low long enough that the far end sees a framing fault, then idle high
          sh_q <= 13'h1000;
          left_q <= BREAK_BITS + 4'h1;
          if (send_kind == KIND_COMMAND) begin
            step_q <= 2'h1;
            cmd_q <= send_data;
          end
        end
      end
    end else if (bit_en) begin
      sh_q <= {1'b1, sh_q[12:1]};
      left_q <= left_q - 4'h1;
      if (left_q == 4'h1) begin
        // Sequence elements follow back to back, nothing else in between
        case (step_q)
          2'h1: begin
            sh_q <= frame_of(CMD_ARM_BYTE, 1'b0, nine_bit);
            left_q <= nine_bit ? 4'hb : 4'ha;
            step_q <= 2'h2;
          end
          2'h2: begin
            sh_q <= 13'h1000;
            left_q <= BREAK_BITS + 4'h1;
            step_q <= 2'h3;
          end
          2'h3: begin
            sh_q <= frame_of(cmd_q, 1'b0, nine_bit);
            left_q <= nine_bit ? 4'hb : 4'ha;
            step_q <= 2'h0;
          end
          default: begin
            busy_q <= 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      send_ready <= 1'b0;
    end else begin
      send_ready <= !busy_q && !(send_valid && send_ready);
    end
  end

  assign link.rx_line = sh_q[0];
endmodule // ufab_host
`default_nettype wire

//--- ufab_device.sv
// Device end: serial port with addressing, command arming, baud and rate error
`timescale 1ns/1ns
`default_nettype none
module ufab_device (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  ufab_link_if.dev link,
  output logic irq,
  output logic soft_reset_req,
  output logic prog_load_req
);
  import ufab_pkg::*;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} ufab_rx_type;
  typedef enum logic [1:0] {CM_IDLE, CM_BRK, CM_FE, CM_ARMED} ufab_cmd_type;

  logic rx_done_q, tx_done_q, rb9_q, tb9_q, rx_en_q, multi_q, sm1_q, sm0_q, fault_q;
  logic rate_doubler_q, fview_q, gen_q;
  logic [7:0] own_q, msk_q, rxbuf_q, rerr_q;
  logic [1:0] imask_q;
  logic [15:0] inc_q;
  logic pend_q, pwr_q;
  logic [7:0] paddr_q;
  logic [2:0] sync_q;
  logic rxl_q, rxp_q;

  // ************************************************************
  // Register bus: one wait state, write lands in the data phase
  // ************************************************************
  logic wr_en;
  logic [7:0] rd_v;
  assign wr_en = pend_q && pwr_q;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= 1'b0;
      pwr_q <= 1'b0;
      paddr_q <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
    end else if (pend_q) begin
      pend_q <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= pwr_q ? 32'h0000_0000 : (paddr_q == OFF_PHASE_INC ? {16'h0000, inc_q} :
                {24'h00_0000, rd_v});
    end else if (hsel && hready && htrans[1]) begin
      pend_q <= 1'b1;
      pwr_q <= hwrite;
      paddr_q <= (haddr[31:8] == 24'h00_0000) ? haddr[7:0] : 8'hff;
      hreadyout <= 1'b0;
    end
  end

  logic [1:0] pending;
  assign pending = {tx_done_q, rx_done_q} & imask_q;

  always_comb begin
    case (paddr_q)
      // One bit position, two stores
      OFF_CTRL: rd_v = {fview_q ? fault_q : sm0_q, sm1_q, multi_q, rx_en_q, tb9_q, rb9_q,
                        tx_done_q, rx_done_q};
      OFF_MODE: rd_v = {5'h00, gen_q, fview_q, rate_doubler_q};
      OFF_DATA: rd_v = rxbuf_q;
      OFF_OWN_ADDR: rd_v = own_q;
      OFF_ADDR_MASK: rd_v = msk_q;
      OFF_IRQ_MASK: rd_v = {6'h00, imask_q};
      OFF_IRQ_FLAGS: rd_v = {6'h00, pending};
      OFF_RATE_ERR: rd_v = rerr_q;
      default: rd_v = 8'h00;
    endcase
  end

  // ************************************************************
  // Plain configuration registers
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {sm0_q, sm1_q, multi_q, rx_en_q, tb9_q} <= RST_CTRL[7:3];
      {gen_q, fview_q, rate_doubler_q} <= RST_MODE;
      own_q <= RST_ADDR;
      msk_q <= RST_ADDR;
      imask_q <= RST_IRQ_MASK;
      inc_q <= RST_PHASE_INC;
    end else if (wr_en) begin
      case (paddr_q)
        OFF_CTRL: begin
          if (!fview_q) begin
            sm0_q <= hwdata[CTRL_MODE_BIT0];
          end
          sm1_q <= hwdata[CTRL_MODE_BIT1];
          multi_q <= hwdata[CTRL_MULTIDROP];
          rx_en_q <= hwdata[CTRL_RX_EN];
          tb9_q <= hwdata[CTRL_TX_BIT9];
        end
        OFF_MODE: begin
          rate_doubler_q <= hwdata[MODE_DOUBLER];
          fview_q <= hwdata[MODE_FAULT_VIEW];
          gen_q <= hwdata[MODE_GEN_EN];
        end
        OFF_OWN_ADDR: own_q <= hwdata[7:0];
        OFF_ADDR_MASK: msk_q <= hwdata[7:0];
        OFF_IRQ_MASK: imask_q <= hwdata[IRQ_TX:IRQ_RX];
        OFF_PHASE_INC: inc_q <= hwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // Baud tick at 16x the bit rate
  // ************************************************************
  logic [16:0] acc_q;
  logic [1:0] pre_q;
  logic half_q;
  logic [17:0] acc_sum;
  logic tick, nine, m2;
  assign nine = sm0_q;
  assign m2 = sm0_q && !sm1_q;
  assign acc_sum = {1'b0, acc_q} + {2'b00, inc_q};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_q <= 17'h0_0000;
      pre_q <= 2'h0;
      half_q <= 1'b0;
    end else begin
      half_q <= !half_q;
      if (gen_q && !m2) begin
        acc_q <= acc_sum[16:0];
        pre_q <= pre_q + {1'b0, acc_sum[17]};
      end
    end
  end

  // Accumulator overflow gives clk*inc/2^17; quarter it unless doubled
  always_comb begin
    if (m2) begin
      tick = rate_doubler_q || half_q;
    end else if (sm1_q) begin
      tick = gen_q && acc_sum[17] && (rate_doubler_q || pre_q == 2'h3);
    end else begin
      tick = 1'b0;
    end
  end

  // ************************************************************
  // Receive line sync and receiver
  // ************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_q <= 3'b111;
      rxl_q <= 1'b1;
      rxp_q <= 1'b1;
    end else begin
      sync_q <= {sync_q[1:0], link.rx_line};
      if (sync_q[1] == sync_q[2]) begin
        rxl_q <= sync_q[2];
      end
      rxp_q <= rxl_q;
    end
  end

  ufab_rx_type rx_q;
  logic [3:0] smp_q, bit_q, eslot_q, eslot_d, esmp_q;
  logic [1:0] vote_q;
  logic [8:0] sh_q;
  logic bitv, mid, word_end, brk, hit, load;
  logic [7:0] rdata;
  logic [5:0] step;
  logic signed [5:0] off;
  logic signed [11:0] prod;
  assign mid = tick && smp_q == VOTE_LAST;
  assign bitv = (vote_q + {1'b0, rxl_q}) >= 2'h2;
  assign word_end = mid && rx_q == RX_STOP;
  assign rdata = nine ? sh_q[7:0] : sh_q[8:1];
  assign brk = !bitv && rdata == 8'h00 && !(nine && sh_q[8]);
  // Own match ignores mask zeros; broadcast ignores zeros of own|mask
  assign hit = (((rdata ^ own_q) & msk_q) == 8'h00) ||
               (((rdata ^ (own_q | msk_q)) & (own_q | msk_q)) == 8'h00);
  assign load = !rx_done_q && (!multi_q || (nine ? (sh_q[8] && hit) : bitv));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_q <= RX_IDLE;
      smp_q <= 4'h0;
      bit_q <= 4'h0;
      vote_q <= 2'h0;
      sh_q <= 9'h000;
      eslot_q <= 4'h0;
      esmp_q <= 4'h0;
    end else begin
      if (rx_q != RX_IDLE && rxl_q != rxp_q) begin
        eslot_q <= eslot_d;
        esmp_q <= smp_q;
      end
      case (rx_q)
        RX_IDLE: begin
          if (rx_en_q && rxp_q && !rxl_q && (m2 || sm1_q)) begin
            rx_q <= RX_START;
            smp_q <= 4'h0;
            vote_q <= 2'h0;
            bit_q <= 4'h0;
          end
        end
        default: begin
          if (tick) begin
            smp_q <= smp_q + 4'h1;
            if (smp_q >= VOTE_FIRST && smp_q < VOTE_LAST) begin
              vote_q <= vote_q + {1'b0, rxl_q};
            end
            if (mid) begin
              vote_q <= 2'h0;
              if (rx_q == RX_START && bitv) begin
                rx_q <= RX_IDLE;
              end else if (rx_q == RX_BITS) begin
                sh_q <= {bitv, sh_q[8:1]};
              end else if (rx_q == RX_STOP) begin
                rx_q <= RX_IDLE;
              end
            end
            if (smp_q == SAMPLE_LAST) begin
              if (rx_q == RX_START) begin
                rx_q <= RX_BITS;
              end else if (rx_q == RX_BITS) begin
                bit_q <= bit_q + 4'h1;
                if (bit_q == (nine ? 4'h8 : 4'h7)) begin
                  rx_q <= RX_STOP;
                end
              end
            end
          end
        end
      endcase
    end
  end

  // Slot of the current sample: start is 0, data bits follow
  assign eslot_d = (rx_q == RX_START) ? 4'h0 : (rx_q == RX_BITS ? bit_q + 4'h1 :
                   (nine ? 4'ha : 4'h9));

  // Boundaries seen early give positive values: sender faster, local slower
  always_comb begin
    if (esmp_q < 4'h8) begin
      off = -$signed({2'b00, esmp_q});
      case (eslot_q)
        4'h1: step = 6'd50;
        4'h2: step = 6'd25;
        4'h3: step = 6'd17;
        4'h4: step = 6'd13;
        4'h5: step = 6'd10;
        4'h6: step = 6'd8;
        4'h7: step = 6'd7;
        4'h8: step = 6'd6;
        4'h9: step = 6'd6;
        4'ha: step = 6'd5;
        default: step = 6'd0;
      endcase
    end else begin
      off = $signed(6'd16 - {2'b00, esmp_q});
      case (eslot_q)
        4'h0: step = 6'd50;
        4'h1: step = 6'd25;
        4'h2: step = 6'd17;
        4'h3: step = 6'd13;
        4'h4: step = 6'd10;
        4'h5: step = 6'd8;
        4'h6: step = 6'd7;
        4'h7: step = 6'd6;
        4'h8: step = 6'd6;
        4'h9: step = 6'd5;
        default: step = 6'd5;
      endcase
    end
    prod = off * $signed({6'b000000, step});
  end

  // ************************************************************
  // Receive flags, rate error and command arming
  // ************************************************************
  ufab_cmd_type cm_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_done_q <= RST_CTRL[CTRL_RX_DONE];
      rb9_q <= RST_CTRL[CTRL_RX_BIT9];
      fault_q <= 1'b0;
      rxbuf_q <= 8'h00;
      rerr_q <= RST_RATE_ERR;
    end else begin
      if (wr_en && paddr_q == OFF_CTRL) begin
        rx_done_q <= hwdata[CTRL_RX_DONE];
        if (fview_q) begin
          fault_q <= hwdata[CTRL_MODE_BIT0];
        end
      end
      if (word_end && !bitv) begin
        fault_q <= 1'b1;
      end
      if (word_end && load) begin
        rx_done_q <= 1'b1;
        rxbuf_q <= rdata;
        rb9_q <= nine ? sh_q[8] : bitv;
        // 0.125% per step, saturated to the register's range
        rerr_q <= prod > 12'sd127 ? 8'h7f : (prod < -12'sd128 ? 8'h80 : prod[7:0]);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cm_q <= CM_IDLE;
      soft_reset_req <= 1'b0;
      prog_load_req <= 1'b0;
    end else begin
      soft_reset_req <= 1'b0;
      prog_load_req <= 1'b0;
      if (word_end) begin
        if (brk) begin
          cm_q <= (cm_q == CM_FE) ? CM_ARMED : CM_BRK;
        end else if (cm_q == CM_BRK && rdata == CMD_ARM_BYTE) begin
          cm_q <= CM_FE;
        end else begin
          cm_q <= CM_IDLE;
          if (cm_q == CM_ARMED) begin
            soft_reset_req <= rdata == CMD_SOFT_RESET;
            prog_load_req <= rdata == CMD_PROG_LOAD;
          end
        end
      end
    end
  end

  // ************************************************************
  // Transmitter and interrupt line
  // ************************************************************
  logic [11:0] tsh_q;
  logic [3:0] tleft_q, tsmp_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tsh_q <= 12'hfff;
      tleft_q <= 4'h0;
      tsmp_q <= 4'h0;
      tx_done_q <= RST_CTRL[CTRL_TX_DONE];
      irq <= 1'b0;
    end else begin
      irq <= |pending;
      if (wr_en && paddr_q == OFF_CTRL) begin
        tx_done_q <= hwdata[CTRL_TX_DONE];
      end
      if (tleft_q == 4'h0) begin
        if (wr_en && paddr_q == OFF_DATA) begin
          // Leading idle slot: line drops on a tick, so every bit lasts 16 ticks
          tsh_q <= nine ? {1'b1, tb9_q, hwdata[7:0], 2'b01} : {2'b11, hwdata[7:0], 2'b01};
          tleft_q <= nine ? 4'hc : 4'hb;
          tsmp_q <= SAMPLE_LAST;
        end
      end else if (tick) begin
        tsmp_q <= tsmp_q + 4'h1;
        if (tsmp_q == SAMPLE_LAST) begin
          tsh_q <= {1'b1, tsh_q[11:1]};
          tleft_q <= tleft_q - 4'h1;
          if (tleft_q == 4'h2) begin
            tx_done_q <= 1'b1;
          end
        end
      end
    end
  end

  assign link.tx_line = tsh_q[0];
endmodule // ufab_device
`default_nettype wire

//--- ufab_monitor.sv
// Concurrent checks on the serial link and the device outputs
`timescale 1ns/1ns
`default_nettype none
module ufab_monitor (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic rx_line,
  input wire logic tx_line,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irq,
  input wire logic soft_reset_req,
  input wire logic prog_load_req
);
  // Longest legal low run: a break at the host rate used for breaks
  localparam int LOW_LIMIT = 400;
  int low_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_q <= 0;
    end else if (rx_line) begin
      low_q <= 0;
    end else if (low_q < 1000) begin
      low_q <= low_q + 1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  property p_one_wait;
    !hreadyout |=> hreadyout;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait state too long");
  property p_soft_pulse;
    soft_reset_req |=> !soft_reset_req;
  endproperty
  a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset not a pulse");
  property p_load_pulse;
    prog_load_req |=> !prog_load_req;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("load request not a pulse");
  property p_req_excl;
    !(soft_reset_req && prog_load_req);
  endproperty
  a_req_excl: assert property (p_req_excl) else $error("both requests at once");
  property p_cmd_in_stop;
    (soft_reset_req || prog_load_req) |-> rx_line && $past(rx_line);
  endproperty
  a_cmd_in_stop: assert property (p_cmd_in_stop) else $error("request outside stop bit");
  property p_break_len;
    low_q <= LOW_LIMIT;
  endproperty
  a_break_len: assert property (p_break_len) else $error("receive line low too long");
  property p_reset_quiet;
    $rose(hresetn) |-> hreadyout && tx_line && !irq;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  property p_start_len;
    $fell(tx_line) |-> (!tx_line) [*8];
  endproperty
  a_start_len: assert property (p_start_len) else $error("start bit too short");
endmodule // ufab_monitor
`default_nettype wire

//--- tb.sv
// Testbench: bus master, host end and device end joined by the link
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ufab_pkg::*;
  logic hclk;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic soft_reset_req;
  logic prog_load_req;
  logic [15:0] bit_cycles = 16'h0020;
  logic nine_bit = 1'b1;
  logic send_valid = 1'b0;
  ufab_kind_type send_kind = KIND_BYTE;
  logic [7:0] send_data = 8'h00;
  logic send_ninth = 1'b0;
  logic send_ready;
  logic tx_w;
  logic [31:0] rd;
  int errors = 0;
  int n_tests = 0;
  int n_soft = 0;
  int n_load = 0;
  int s0;
  int l0;
  int n;
  logic [7:0] b_ctrl[5] = '{8'h90, 8'h90, 8'hd0, 8'hd0, 8'h50};
  logic [7:0] b_mode[5] = '{8'h00, 8'h01, 8'h05, 8'h04, 8'h05};
  int b_len[5] = '{320, 160, 640, 2560, 576};
  logic [7:0] md_d[5] = '{8'hf0, 8'hf5, 8'hf2, 8'hfa, 8'hf0};
  logic md_n[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic [7:0] md_e[5] = '{8'hb5, 8'hb5, 8'hb4, 8'hb5, 8'hb4};
  logic [7:0] cm[3] = '{8'hfe, 8'hfd, 8'h55};
  int es[3] = '{1, 0, 0};
  int el[3] = '{0, 1, 0};
  ufab_link_if link();
  ufab_device i_ufab_device (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .link(link), .irq(irq),
    .soft_reset_req(soft_reset_req), .prog_load_req(prog_load_req));
  ufab_host i_ufab_host (.hclk(hclk), .hresetn(hresetn), .link(link),
    .bit_cycles(bit_cycles), .nine_bit(nine_bit), .send_valid(send_valid), .send_kind(send_kind),
    .send_data(send_data), .send_ninth(send_ninth), .send_ready(send_ready));
  ufab_monitor i_ufab_monitor (.hclk(hclk), .hresetn(hresetn), .rx_line(link.rx_line),
    .tx_line(link.tx_line), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .soft_reset_req(soft_reset_req), .prog_load_req(prog_load_req));
  always_comb tx_w = link.tx_line;
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (soft_reset_req === 1'b1) n_soft <= n_soft + 1;
    if (prog_load_req === 1'b1) n_load <= n_load + 1;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic final_report();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Reads the value seen before this edge lands, as a sampler would
  task automatic wait_for(ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim && s !== v; i++) @(posedge hclk);
    if (s !== v) begin
      errors++;
      final_report();
    end
  endtask
  // htrans is left idle so a following call sets it only once per step
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    wait_for(hreadyout, 1'b1, 50);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    wait_for(hreadyout, 1'b1, 50);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic send(input ufab_kind_type k, input logic [7:0] d, input logic n9);
    send_valid <= 1'b1;
    send_kind <= k;
    send_data <= d;
    send_ninth <= n9;
    @(posedge hclk);
    wait_for(send_ready, 1'b1, 100);
    send_valid <= 1'b0;
    @(posedge hclk);
    wait_for(send_ready, 1'b0, 4);
    wait_for(send_ready, 1'b1, 30000);
    repeat (8) @(posedge hclk);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (n = 0; n <= 36; n += 4) rdchk(n[7:0], 32'h0);
    wr(OFF_RATE_ERR, 32'hff);
    rdchk(OFF_RATE_ERR, 32'h0);
    wr(OFF_PHASE_INC, 32'h8000);
    wr(OFF_IRQ_MASK, 32'h2);
    foreach (b_ctrl[i]) begin
      wr(OFF_CTRL, {24'h0, b_ctrl[i]});
      wr(OFF_MODE, {24'h0, b_mode[i]});
      wr(OFF_DATA, 32'h0);
      wait_for(tx_w, 1'b0, 200);
      for (n = 0; tx_w === 1'b0 && n < 5000; n++) @(posedge hclk);
      check(n, b_len[i]);
      repeat (b_len[i] / 5) @(posedge hclk);
    end
    // Mode 1 receive: eight data bits, doubled accumulator rate
    nine_bit <= 1'b0;
    bit_cycles <= 16'h0040;
    send(KIND_BYTE, 8'hc5, 1'b0);
    rdchk(OFF_DATA, 32'hc5);
    nine_bit <= 1'b1;
    bit_cycles <= 16'h0020;
    rdchk(OFF_IRQ_FLAGS, 32'h2);
    check({31'h0, irq}, 32'h1);
    wr(OFF_CTRL, 32'h90);
    rdchk(OFF_IRQ_FLAGS, 32'h0);
    check({31'h0, irq}, 32'h0);
    wr(OFF_MODE, 32'h0);
    wr(OFF_IRQ_MASK, 32'h1);
    send(KIND_BYTE, 8'h5a, 1'b0);
    rdchk(OFF_CTRL, 32'h91);
    rdchk(OFF_DATA, 32'h5a);
    rdchk(OFF_IRQ_FLAGS, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(OFF_CTRL, 32'h90);
    // Irq is registered one cycle behind the flags
    @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    wr(OFF_IRQ_MASK, 32'h0);
    send(KIND_BYTE, 8'ha5, 1'b0);
    rdchk(OFF_IRQ_FLAGS, 32'h0);
    wr(OFF_IRQ_MASK, 32'h1);
    rdchk(OFF_IRQ_FLAGS, 32'h1);
    wr(OFF_CTRL, 32'h90);
    // A fast sender reads positive, a slow one negative
    for (n = 0; n < 2; n++) begin
      bit_cycles <= n[0] ? 16'h0021 : 16'h001f;
      send(KIND_BYTE, 8'h00, 1'b0);
      bus(1'b0, OFF_RATE_ERR, 32'h0);
      check(rd >> 8, 32'h0);
      check({30'h0, rd[7], |rd[7:0]}, n[0] ? 32'h3 : 32'h1);
      // Trim by a small share of the error only, so the setting settles
      l0 = 32768 + 4 * int'($signed(rd[7:0]));
      wr(OFF_PHASE_INC, l0);
      rdchk(OFF_PHASE_INC, l0);
      wr(OFF_CTRL, 32'h90);
    end
    bit_cycles <= 16'h0020;
    send(KIND_BREAK, 8'h00, 1'b0);
    wr(OFF_CTRL, 32'h90);
    wr(OFF_MODE, 32'h2);
    send(KIND_BYTE, 8'h3c, 1'b0);
    rdchk(OFF_CTRL, 32'h91);
    rdchk(OFF_DATA, 32'h3c);
    wr(OFF_CTRL, 32'h10);
    rdchk(OFF_CTRL, 32'h10);
    wr(OFF_MODE, 32'h0);
    rdchk(OFF_CTRL, 32'h90);
    wr(OFF_OWN_ADDR, 32'hf0);
    wr(OFF_ADDR_MASK, 32'hfa);
    wr(OFF_CTRL, 32'hb0);
    foreach (md_d[i]) begin
      send(KIND_BYTE, md_d[i], md_n[i]);
      rdchk(OFF_CTRL, {24'h0, md_e[i]});
      wr(OFF_CTRL, 32'hb0);
    end
    wr(OFF_CTRL, 32'h90);
    foreach (cm[i]) begin
      s0 = n_soft;
      l0 = n_load;
      send(KIND_COMMAND, cm[i], 1'b0);
      check(n_soft - s0, es[i]);
      check(n_load - l0, el[i]);
    end
    s0 = n_soft + n_load;
    send(KIND_BREAK, 8'h00, 1'b0);
    send(KIND_BYTE, 8'hfe, 1'b0);
    send(KIND_BYTE, 8'h11, 1'b0);
    send(KIND_BREAK, 8'h00, 1'b0);
    send(KIND_BYTE, 8'hfd, 1'b0);
    check(n_soft + n_load - s0, 32'h0);
    final_report();
  end
endmodule // tb
`default_nettype wire
